// [shared/freq_meter_pkg.sv]
// package: register map, field layout and timing constants of the frequency meter
package freq_meter_pkg;
   localparam int ADDR_W = 10;
   localparam logic [9:0] OFS_START_CMD = 10'h000;
   localparam logic [9:0] OFS_CONFIG = 10'h004;
   localparam logic [9:0] OFS_STATE = 10'h008;
   localparam logic [9:0] OFS_COUNT = 10'h00c;
   localparam logic [9:0] OFS_IRQ_EN_SET = 10'h010;
   localparam logic [9:0] OFS_IRQ_EN_CLR = 10'h014;
   localparam logic [9:0] OFS_IRQ_MASK = 10'h018;
   localparam logic [9:0] OFS_IRQ_PEND = 10'h01c;
   localparam logic [9:0] OFS_IRQ_PEND_CLR = 10'h020;
   localparam logic [9:0] OFS_REVISION = 10'h3fc;
   // configuration fields
   localparam int CFG_REF_EN_BIT = 31;
   localparam int CFG_MSR_SEL_LSB = 16;
   localparam int MSR_SEL_W = 5;
   localparam int CFG_WIN_LSB = 8;
   localparam int WIN_W = 8;
   localparam int CFG_REF_SEL_LSB = 0;
   localparam int REF_SEL_W = 3;
   localparam logic [31:0] CFG_RESET = 32'h0000_0000;
   localparam logic [31:0] CFG_WRITABLE = 32'h801f_ff07;
   // status and interrupt bits
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_SWITCH_BIT = 1;
   localparam int START_BIT = 0;
   localparam int RESULT_W = 24;
   localparam int NUM_MSR_SRC = 32;
   localparam int NUM_REF_SRC = 8;
   // reference edges seen before a clock switch counts as settled
   localparam logic [1:0] SWITCH_EDGES = 2'h2;
   // arbitrary revision value
   localparam logic [31:0] REVISION_VALUE = 32'h0000_0a01;
endpackage : freq_meter_pkg

// [design/clock_frequency_meter_regs.sv]
// frequency meter: register slave, reference switch control and edge counter
`timescale 1ns/1ps
module clock_frequency_meter_regs (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   // register port
   input wire logic [9:0] addr_i,
   input wire logic [31:0] wr_data_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rd_data_o,
   // on-chip clock sources, sampled as levels
   input wire logic [31:0] msr_src_i,
   input wire logic [7:0] ref_src_i,
   // interrupt
   output logic irq_o
);
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_ARM = 3'b010,
      ST_COUNT = 3'b100
   } meter_state_t;

   meter_state_t state_r;
   logic [31:0] cfg_r;
   logic switching_r;
   logic [1:0] sw_edges_r;
   logic [2:0] msr_sync_r;
   logic [2:0] ref_sync_r;
   logic [7:0] ref_cnt_r;
   logic [23:0] count_r;
   logic [23:0] result_r;
   logic [1:0] mask_r;
   logic [1:0] pend_r;
   logic busy_d_r;
   logic switching_d_r;
   logic msr_edge;
   logic ref_edge;
   logic busy;
   logic start_req;
   logic cfg_wr;
   logic [1:0] pend_set;
   logic [1:0] pend_clr;
   logic [31:0] rd_nxt;

   function automatic logic is_wr(input logic [9:0] ofs);
      is_wr = wr_i && (addr_i == ofs);
   endfunction : is_wr

   // field extraction, positioned by the package constants
   function automatic logic [7:0] win_len(input logic [31:0] cfg);
      win_len = cfg[freq_meter_pkg::CFG_WIN_LSB +: freq_meter_pkg::WIN_W];
   endfunction : win_len

   function automatic logic [4:0] msr_sel(input logic [31:0] cfg);
      msr_sel = cfg[freq_meter_pkg::CFG_MSR_SEL_LSB +: freq_meter_pkg::MSR_SEL_W];
   endfunction : msr_sel

   function automatic logic [2:0] ref_sel(input logic [31:0] cfg);
      ref_sel = cfg[freq_meter_pkg::CFG_REF_SEL_LSB +: freq_meter_pkg::REF_SEL_W];
   endfunction : ref_sel

   // true on the reference edge that closes the window
   function automatic logic win_last(input logic [7:0] cnt, input logic [7:0] len);
      win_last = (cnt + 8'h01 == len);
   endfunction : win_last

   // saturating step shared by the counter and the result capture
   function automatic logic [23:0] count_step(input logic [23:0] cnt, input logic hit);
      count_step = (hit && cnt != 24'hffffff) ? cnt + 24'h000001 : cnt;
   endfunction : count_step

   function automatic logic [1:0] wr_bits(input logic [9:0] ofs);
      wr_bits = is_wr(ofs) ? wr_data_i[1:0] : 2'h0;
   endfunction : wr_bits

   assign busy = (state_r != ST_IDLE);
   assign cfg_wr = is_wr(freq_meter_pkg::OFS_CONFIG);
   assign start_req = is_wr(freq_meter_pkg::OFS_START_CMD) &&
      wr_data_i[freq_meter_pkg::START_BIT];

   // configuration register
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         cfg_r <= freq_meter_pkg::CFG_RESET;
      end else if (cfg_wr) begin
         cfg_r <= wr_data_i & freq_meter_pkg::CFG_WRITABLE;
      end
   end

   // source selection and synchronisers; stage 0 feeds stage 1 only
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         msr_sync_r <= 3'h0;
         ref_sync_r <= 3'h0;
      end else begin
         msr_sync_r <= {msr_sync_r[1:0], msr_src_i[msr_sel(cfg_r)]};
         ref_sync_r <= {ref_sync_r[1:0],
            ref_src_i[ref_sel(cfg_r)] & cfg_r[freq_meter_pkg::CFG_REF_EN_BIT]};
      end
   end
   assign msr_edge = msr_sync_r[1] && !msr_sync_r[2];
   assign ref_edge = ref_sync_r[1] && !ref_sync_r[2];

   // reference switch: busy until selected source shows settled edges, or cleared at once while the reference is disabled
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         switching_r <= 1'b0;
         sw_edges_r <= 2'h0;
      end else if (cfg_wr) begin
         switching_r <= 1'b1;
         sw_edges_r <= 2'h0;
      end else if (switching_r) begin
         if (!cfg_r[freq_meter_pkg::CFG_REF_EN_BIT] ||
             (ref_edge && sw_edges_r == freq_meter_pkg::SWITCH_EDGES - 2'h1)) begin
            switching_r <= 1'b0;
         end else if (ref_edge) begin
            sw_edges_r <= sw_edges_r + 2'h1;
         end
      end
   end

   // measurement sequencer
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         state_r <= ST_IDLE;
         ref_cnt_r <= 8'h00;
         count_r <= 24'h000000;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (start_req) begin
                  state_r <= ST_ARM;
               end
            end
            ST_ARM: begin
               ref_cnt_r <= 8'h00;
               count_r <= 24'h000000;
               if (ref_edge) begin
                  state_r <= (win_len(cfg_r) == 8'h00) ? ST_IDLE : ST_COUNT;
               end
            end
            ST_COUNT: begin
               count_r <= count_step(count_r, msr_edge);
               if (ref_edge) begin
                  ref_cnt_r <= ref_cnt_r + 8'h01;
                  if (win_last(ref_cnt_r, win_len(cfg_r))) begin
                     state_r <= ST_IDLE;
                  end
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // result captured as the window closes
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         result_r <= 24'h000000;
      end else if (state_r == ST_ARM && ref_edge && win_len(cfg_r) == 8'h00) begin
         result_r <= 24'h000000;
      end else if (state_r == ST_COUNT && ref_edge && win_last(ref_cnt_r, win_len(cfg_r))) begin
         result_r <= count_step(count_r, msr_edge);
      end
   end

   // interrupt: events are falling edges of busy and switching
   assign pend_set = {switching_d_r && !switching_r, busy_d_r && !busy};
   assign pend_clr = wr_bits(freq_meter_pkg::OFS_IRQ_PEND_CLR) |
      ((rd_i && addr_i == freq_meter_pkg::OFS_IRQ_PEND) ? 2'h3 : 2'h0);

   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         busy_d_r <= 1'b0;
         switching_d_r <= 1'b0;
         pend_r <= 2'h0;
      end else begin
         busy_d_r <= busy;
         switching_d_r <= switching_r;
         pend_r <= (pend_r & ~pend_clr) | pend_set;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         mask_r <= 2'h0;
      end else begin
         mask_r <= (mask_r | wr_bits(freq_meter_pkg::OFS_IRQ_EN_SET)) &
            ~wr_bits(freq_meter_pkg::OFS_IRQ_EN_CLR);
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(((pend_r & ~pend_clr) | pend_set) & mask_r);
      end
   end

   // read mux, data valid the cycle after the strobe
   always_comb begin
      rd_nxt = 32'h0000_0000;
      case (addr_i)
         freq_meter_pkg::OFS_CONFIG: rd_nxt = cfg_r;
         freq_meter_pkg::OFS_STATE: rd_nxt = {30'h0, switching_r, busy};
         freq_meter_pkg::OFS_COUNT: rd_nxt = {8'h00, result_r};
         freq_meter_pkg::OFS_IRQ_MASK: rd_nxt = {30'h0, mask_r};
         freq_meter_pkg::OFS_IRQ_PEND: rd_nxt = {30'h0, pend_r};
         freq_meter_pkg::OFS_REVISION: rd_nxt = freq_meter_pkg::REVISION_VALUE;
         default: rd_nxt = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         rd_data_o <= 32'h0000_0000;
      end else if (rd_i) begin
         rd_data_o <= rd_nxt;
      end else begin
         rd_data_o <= 32'h0000_0000;
      end
   end

   // checks: sequencer and measurement
   a_start_arms: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (state_r == ST_IDLE && start_req) |=> state_r == ST_ARM)
      else $error("start did not arm measurement");

   a_zero_start_idle: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (state_r == ST_IDLE && !start_req) |=> state_r == ST_IDLE)
      else $error("idle left without start");

   a_start_busy_ignored: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (state_r == ST_ARM && start_req && !ref_edge) |=> state_r == ST_ARM)
      else $error("start accepted while busy");

   a_arm_to_count: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (state_r == ST_ARM && ref_edge && win_len(cfg_r) != 8'h00) |=>
      state_r == ST_COUNT && ref_cnt_r == 8'h00 && count_r == 24'h000000)
      else $error("window did not open");

   a_zero_window: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (state_r == ST_ARM && ref_edge && win_len(cfg_r) == 8'h00) |=>
      state_r == ST_IDLE && result_r == 24'h000000)
      else $error("empty window not closed at once");

   a_busy_ends: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (state_r == ST_COUNT && ref_edge && win_last(ref_cnt_r, win_len(cfg_r))) |=>
      !busy ##1 pend_r[0])
      else $error("busy did not end with window");

   a_count_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (state_r == ST_COUNT && !msr_edge) |=> count_r == $past(count_r) || state_r != ST_COUNT)
      else $error("count moved without measured edge");

   a_count_step: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (state_r == ST_COUNT && msr_edge && count_r != 24'hffffff) |=>
      count_r == $past(count_r) + 24'h000001)
      else $error("measured edge not counted");

   a_result_capture: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (state_r == ST_COUNT && ref_edge && win_last(ref_cnt_r, win_len(cfg_r))) |=>
      result_r == count_r)
      else $error("result not taken from final count");

   a_result_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      state_r == ST_IDLE |=> $stable(result_r))
      else $error("result changed while idle");

   // checks: configuration and reference switch
   a_cfg_write: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      cfg_wr |=> cfg_r[31] == $past(wr_data_i[31]) && cfg_r[15:8] == $past(wr_data_i[15:8]))
      else $error("config not stored");

   a_cfg_fields: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      cfg_wr |=> msr_sel(cfg_r) == $past(wr_data_i[20:16]) &&
      ref_sel(cfg_r) == $past(wr_data_i[2:0]) && cfg_r[30:21] == 10'h000)
      else $error("config selects not stored");

   a_ref_gated: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      !cfg_r[freq_meter_pkg::CFG_REF_EN_BIT] |=> !ref_sync_r[0])
      else $error("reference passed while disabled");

   a_switch_set: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      cfg_wr |=> switching_r)
      else $error("reference busy not set by config write");

   a_switch_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (switching_r && cfg_r[freq_meter_pkg::CFG_REF_EN_BIT] && !cfg_wr && !ref_edge) |=>
      switching_r)
      else $error("reference busy dropped without edge");

   a_switch_disable_ready: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (switching_r && !cfg_r[freq_meter_pkg::CFG_REF_EN_BIT] && !cfg_wr) |=> !switching_r)
      else $error("disabled reference not ready");

   // checks: interrupt and register port
   a_pend_done: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      $fell(switching_r) |=> pend_r[1])
      else $error("ready flag not pending");

   a_pend_busy_fall: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (busy_d_r && !busy) |=> pend_r[0])
      else $error("done flag not pending");

   a_pend_sticky: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (pend_r[0] && !pend_clr[0]) |=> pend_r[0])
      else $error("done flag lost without clear");

   a_pend_read_clear: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (rd_i && addr_i == freq_meter_pkg::OFS_IRQ_PEND && pend_set == 2'h0) |=>
      pend_r == 2'h0)
      else $error("pending not cleared by read");

   a_mask_set: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (wr_i && addr_i == freq_meter_pkg::OFS_IRQ_EN_SET) |=>
      (mask_r & $past(wr_data_i[1:0])) == $past(wr_data_i[1:0]))
      else $error("mask bit not set");

   a_mask_clear: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (wr_i && addr_i == freq_meter_pkg::OFS_IRQ_EN_CLR) |=>
      (mask_r & $past(wr_data_i[1:0])) == 2'h0)
      else $error("mask bit not cleared");

   a_irq_level: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      1'b1 |=> irq_o == |(pend_r & $past(mask_r)))
      else $error("interrupt level wrong");

   a_status_read: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (rd_i && addr_i == freq_meter_pkg::OFS_STATE) |=> rd_data_o[0] == $past(busy) &&
      rd_data_o[1] == $past(switching_r) && rd_data_o[31:2] == 30'h0)
      else $error("status read wrong");

   a_result_upper: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (rd_i && addr_i == freq_meter_pkg::OFS_COUNT) |=> rd_data_o[31:24] == 8'h00)
      else $error("result upper bits not zero");

   a_revision_const: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (rd_i && addr_i == freq_meter_pkg::OFS_REVISION) |=>
      rd_data_o == freq_meter_pkg::REVISION_VALUE)
      else $error("revision read wrong");

   a_read_idle_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      !rd_i |=> rd_data_o == 32'h0000_0000)
      else $error("read data outside its cycle");

   c_measure_done: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      state_r == ST_COUNT ##1 state_r == ST_IDLE);
   c_switch_done: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      $fell(switching_r));
   c_irq_high: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i) $rose(irq_o));
   c_start_refused: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      state_r != ST_IDLE && start_req);
   c_pend_read_clear: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      rd_i && addr_i == freq_meter_pkg::OFS_IRQ_PEND && pend_r != 2'h0);
endmodule : clock_frequency_meter_regs

// [dv/testbench.sv]
// testbench: self-checking register and measurement scenarios for the frequency meter
`timescale 1ns/1ps
`define CHK(what, exp, got) begin compares++; if ((got) !== (exp)) begin mismatches++; \
   $display("mismatch %s expected %h seen %h", what, exp, got); end end
module testbench;
   logic sys_clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [9:0] addr_i = 10'h000;
   logic [31:0] wr_data_i = 32'h0000_0000;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [31:0] rd_data_o;
   logic [31:0] msr_src_i = 32'h0000_0000;
   logic [7:0] ref_src_i = 8'h00;
   logic irq_o;
   logic [7:0] phase = 8'h00;
   logic [31:0] d;
   int mismatches = 0;
   int compares = 0;

   clock_frequency_meter_regs clock_frequency_meter_regs_i (
      .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
      .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .msr_src_i(msr_src_i),
      .ref_src_i(ref_src_i), .irq_o(irq_o));

   initial begin
      forever #4 sys_clk_i = ~sys_clk_i;
   end

   // sources: edges never coincide, so counts per reference period are exact
   always @(posedge sys_clk_i) begin
      phase <= phase + 8'h01;
      msr_src_i[5] <= phase[2];
      msr_src_i[4] <= phase[3];
      ref_src_i[2] <= phase[4];
      ref_src_i[3] <= phase[5];
   end

   task automatic give_verdict();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : give_verdict

   task automatic wr(input logic [9:0] a, input logic [31:0] v);
      @(posedge sys_clk_i);
      addr_i <= a;
      wr_data_i <= v;
      wr_i <= 1'b1;
      @(posedge sys_clk_i);
      wr_i <= 1'b0;
   endtask : wr

   task automatic rd(input logic [9:0] a);
      @(posedge sys_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge sys_clk_i);
      rd_i <= 1'b0;
      #1 d = rd_data_o;
   endtask : rd

   task automatic wait_bit(input int b, input logic v);
      int n;
      n = 0;
      rd(freq_meter_pkg::OFS_STATE);
      while (d[b] !== v && n < 500) begin
         rd(freq_meter_pkg::OFS_STATE);
         n++;
      end
      if (n >= 500) begin
         mismatches++;
         $display("mismatch status wait expected %h seen %h", v, d[b]);
         give_verdict();
      end
   endtask : wait_bit

   task automatic t_reset();
      logic [9:0] ofs [6];
      ofs = '{10'h004, 10'h008, 10'h00c, 10'h018, 10'h01c, 10'h100};
      foreach (ofs[i]) begin
         rd(ofs[i]);
         `CHK("reset value", 32'h0000_0000, d)
      end
      rd(freq_meter_pkg::OFS_REVISION);
      `CHK("revision", freq_meter_pkg::REVISION_VALUE, d)
      @(posedge sys_clk_i);
      #1 `CHK("read data one cycle", 32'h0000_0000, rd_data_o)
      `CHK("irq after reset", 1'b0, irq_o)
   endtask : t_reset

   task automatic t_config();
      wr(freq_meter_pkg::OFS_CONFIG, 32'hffff_ffff);
      rd(freq_meter_pkg::OFS_STATE);
      `CHK("switching set", 32'h0000_0002, d)
      rd(freq_meter_pkg::OFS_CONFIG);
      `CHK("config fields", 32'h801f_ff07, d)
      wr(freq_meter_pkg::OFS_CONFIG, 32'h001f_ff07);
      wait_bit(1, 1'b0);
      `CHK("ref disabled ready", 1'b0, d[1])
      rd(freq_meter_pkg::OFS_CONFIG);
      `CHK("ref disabled", 32'h001f_ff07, d)
   endtask : t_config

   task automatic t_measure();
      wr(freq_meter_pkg::OFS_CONFIG, 32'h0005_0402);
      wait_bit(1, 1'b0);
      wr(freq_meter_pkg::OFS_CONFIG, 32'h8005_0402);
      wait_bit(1, 1'b0);
      wr(freq_meter_pkg::OFS_IRQ_EN_SET, 32'h0000_0001);
      rd(freq_meter_pkg::OFS_IRQ_MASK);
      `CHK("mask set", 32'h0000_0001, d)
      wr(freq_meter_pkg::OFS_IRQ_PEND_CLR, 32'h0000_0003);
      wr(freq_meter_pkg::OFS_START_CMD, 32'hffff_fffe);
      rd(freq_meter_pkg::OFS_STATE);
      `CHK("start zero idle", 32'h0000_0000, d)
      wr(freq_meter_pkg::OFS_COUNT, 32'h0000_00ff);
      wr(freq_meter_pkg::OFS_START_CMD, 32'h0000_0001);
      rd(freq_meter_pkg::OFS_STATE);
      `CHK("busy", 32'h0000_0001, d)
      wr(freq_meter_pkg::OFS_START_CMD, 32'h0000_0001);
      #1 `CHK("irq while busy", 1'b0, irq_o)
      wait_bit(0, 1'b0);
      repeat (4) @(posedge sys_clk_i);
      #1 `CHK("irq on done", 1'b1, irq_o)
      rd(freq_meter_pkg::OFS_COUNT);
      `CHK("result", 32'h0000_0010, d)
      rd(freq_meter_pkg::OFS_IRQ_PEND);
      `CHK("pending done", 32'h0000_0001, d)
      repeat (2) @(posedge sys_clk_i);
      #1 `CHK("irq after clear", 1'b0, irq_o)
   endtask : t_measure

   task automatic t_masked();
      wr(freq_meter_pkg::OFS_CONFIG, 32'h0005_0402);
      wait_bit(1, 1'b0);
      wr(freq_meter_pkg::OFS_CONFIG, 32'h0004_0203);
      wait_bit(1, 1'b0);
      wr(freq_meter_pkg::OFS_CONFIG, 32'h8004_0203);
      wait_bit(1, 1'b0);
      wr(freq_meter_pkg::OFS_IRQ_EN_CLR, 32'h0000_0001);
      rd(freq_meter_pkg::OFS_IRQ_MASK);
      `CHK("mask clear", 32'h0000_0000, d)
      wr(freq_meter_pkg::OFS_IRQ_PEND_CLR, 32'h0000_0003);
      wr(freq_meter_pkg::OFS_START_CMD, 32'h0000_0001);
      wait_bit(0, 1'b0);
      repeat (4) @(posedge sys_clk_i);
      #1 `CHK("irq masked", 1'b0, irq_o)
      rd(freq_meter_pkg::OFS_COUNT);
      `CHK("result short", 32'h0000_0008, d)
      rd(freq_meter_pkg::OFS_IRQ_PEND);
      `CHK("pending masked", 32'h0000_0001, d)
      wr(freq_meter_pkg::OFS_CONFIG, 32'h8004_0003);
      wait_bit(1, 1'b0);
      wr(freq_meter_pkg::OFS_START_CMD, 32'h0000_0001);
      wait_bit(0, 1'b0);
      rd(freq_meter_pkg::OFS_COUNT);
      `CHK("result empty window", 32'h0000_0000, d)
   endtask : t_masked

   initial begin
      repeat (10) @(posedge sys_clk_i);
      rst_b_i <= 1'b1;
      t_reset();
      t_config();
      t_measure();
      t_masked();
      give_verdict();
   end
endmodule : testbench
